// ---- kss_checksum.sv ----
// Continuous 8-bit end-around-carry checksum over the setup memory.
// Assumes the memory returns data one clock after the address.
`timescale 1ns/100ps
module kss_checksum #(
  parameter int DEPTH  = 256,
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              srst,
  output logic [ADDR_W-1:0]      mem_addr,
  input  wire logic [7:0]        mem_data,
  output logic [7:0]             sum
);
  import kss_pkg::*;

  localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(DEPTH - 1);
  localparam logic [ADDR_W-1:0] ADDR_ZERO = '0;

  if (DEPTH < 2 || DEPTH > (1 << ADDR_W)) begin : g_bad_depth
    $error("kss_checksum: DEPTH does not fit ADDR_W");
  end

  logic [ADDR_W-1:0] addr_q;
  logic              vld_q;
  logic              last_q;
  logic [7:0]        acc_q;
  logic [7:0]        sum_q;
  logic [8:0]        raw;
  logic [7:0]        folded;

  // Carry folds back into bit 0, so a single changed byte moves the sum unless it swaps 8'h00 and 8'hff
  always_comb begin
    raw    = {1'b0, acc_q} + {1'b0, mem_data};
    folded = raw[7:0] + {7'h00, raw[8]};
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      addr_q <= ADDR_ZERO;
      vld_q  <= 1'b0;
      last_q <= 1'b0;
    end else begin
      addr_q <= (addr_q == LAST_ADDR) ? ADDR_ZERO : addr_q + 1'b1;
      vld_q  <= 1'b1;
      last_q <= (addr_q == LAST_ADDR);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      acc_q <= BYTE_ZERO;
      sum_q <= BYTE_ZERO;
    end else if (vld_q) begin
      acc_q <= last_q ? BYTE_ZERO : folded;
      if (last_q)
        sum_q <= folded;
    end
  end

  assign mem_addr = addr_q;
  assign sum      = sum_q;

endmodule

// ---- kss_far_model.sv ----
// Far-side model: per-key readings and setup memory for the interpreter.
// Assumes the interpreter reads memory one clock after the address.
package kss_tb_pkg;
  import kss_pkg::*;

  // Odd keys get a low reference, so their delta clamps to zero
  function automatic kss_key_data_type key_val(input logic [5:0] k);
    key_val.signal            = 8'h40 + {2'h0, k};
    key_val.reference         = k[0] ? 8'h10 : 8'h90;
    key_val.ladder_dac_offset = {2'h2, k};
    key_val.cancel_cap_state  = 2'(k % 6'h03);
    key_val.integrator        = 8'hc0 ^ {2'h0, k};
  endfunction

  // One byte can be altered to show that a lone change moves the sum
  function automatic logic [7:0] mem_val(input logic [3:0] a,
                                         input logic       flip);
    mem_val = {4'h0, a} * 8'h1d + 8'h07;
    if (flip && a == 4'h3) begin
      mem_val = mem_val ^ 8'h01;
    end
  endfunction
endpackage

`timescale 1ns/100ps
module kss_far_model (
  input  wire logic              clk,
  input  wire logic [5:0]        key_index,
  input  wire logic [3:0]        mem_addr,
  input  wire logic              flip,
  output kss_pkg::kss_key_data_type key_data,
  output logic [7:0]             mem_data
);
  import kss_tb_pkg::*;

  assign key_data = key_val(key_index);

  // Registered read: data follows the address by one clock
  always_ff @(posedge clk) begin
    mem_data <= mem_val(mem_addr, flip);
  end
endmodule

// ---- kss_interp.sv ----
// Key scope and single-key status command interpreter.
// Assumes framed command bytes arrive as one-cycle strobes on CLK and that
// per-key readings for KEY_INDEX are valid in the same cycle.
//
// Overview of operation
// - The last valid scope command stays in force for all later commands
// - Reset sets the scope to all keys
// - Single-key commands use the lowest key inside the current scope
// - Key index equals row plus eight times column
// - Keys are acquired in ascending index order, rows first
// - Single-key scope takes a key 0..63 then echoes the command
// - All-keys scope echoes and addresses key zero for single-key use
// - Row scope takes row 0..7, echoes, addresses column zero
// - Column scope takes column 0..7, echoes, addresses row zero
// - Status queries are answered in get or put direction
// - Signal query returns the scoped key's eight-bit signal
// - Delta query returns reference minus signal, zero if negative
// - Reference query returns the scoped key's reference byte
// - Ladder offset query returns the scoped key's ladder setting
// - Cancel capacitor query returns zero to three for the key
// - Integrator query returns the scoped key's integrator count
// - Checksum query returns fold-back sum over setup memory
// - A single changed memory byte changes the checksum unless it swaps 8'h00 and 8'hff
// - Memory error flag comes from its own input, not the checksum
// - General status query returns one byte regardless of scope
// - Status bits: detect, recal, error, sync fail, mismatch
// - Unknown commands are dropped without any reply
`timescale 1ns/100ps
module kss_interp #(
  parameter int MEM_DEPTH  = 256,
  parameter int MEM_ADDR_W = 8
) (
  input  wire logic                      CLK,
  input  wire logic                      SRST,
  input  wire logic                      CMD_VALID,
  input  wire logic [7:0]                CMD_BYTE,
  output logic                           RSP_VALID,
  output logic [7:0]                     RSP_BYTE,
  output logic [kss_pkg::KEY_W-1:0]      KEY_INDEX,
  input  wire kss_pkg::kss_key_data_type KEY_DATA,
  input  wire kss_pkg::kss_status_type   STATUS_IN,
  output logic [MEM_ADDR_W-1:0]          MEM_ADDR,
  input  wire logic [7:0]                MEM_DATA
);
  import kss_pkg::*;

  // Checked here too, so a bad pair is reported against the top level
  if (MEM_DEPTH < 2 || MEM_DEPTH > (1 << MEM_ADDR_W)) begin : g_bad_mem
    $error("kss_interp: MEM_DEPTH does not fit MEM_ADDR_W");
  end

  typedef enum logic {
    ST_IDLE,
    ST_ARG
  } kss_state_type;

  kss_state_type     state_q;
  logic [7:0]        op_q;
  kss_scope_type     scope_type_q;
  logic [KEY_W-1:0]  scope_idx_q;
  logic              rsp_valid_q;
  logic [7:0]        rsp_byte_q;
  logic [7:0]        chk_sum;
  logic [KEY_W-1:0]  lowest_key;
  logic [7:0]        delta;
  logic              arg_take;
  logic              arg_ok;
  logic              idle_take;
  logic              is_query;
  logic              is_two_byte;

  kss_checksum #(
    .DEPTH  (MEM_DEPTH),
    .ADDR_W (MEM_ADDR_W)
  ) u_checksum (
    .clk      (CLK),
    .srst     (SRST),
    .mem_addr (MEM_ADDR),
    .mem_data (MEM_DATA),
    .sum      (chk_sum)
  );

  // Lowest-ranked key of the scope; index is {column, row}
  always_comb begin
    case (scope_type_q)
      SCOPE_KEY: lowest_key = scope_idx_q;
      SCOPE_ROW: lowest_key = {COORD_ZERO, scope_idx_q[COORD_W-1:0]};
      SCOPE_COL: lowest_key = {scope_idx_q[COORD_W-1:0], COORD_ZERO};
      SCOPE_ALL: lowest_key = KEY_ZERO;
      default:   lowest_key = KEY_ZERO;
    endcase
  end
  // Ascending index order is row-first, so scanning logic can use it as is
  assign KEY_INDEX = lowest_key;

  // Saturating difference: a signal above reference means no touch
  assign delta = (KEY_DATA.reference >= KEY_DATA.signal) ?
                 KEY_DATA.reference - KEY_DATA.signal : BYTE_ZERO;

  // No direction input is consulted: queries answer in either mode
  assign is_query = (CMD_BYTE >= CMD_SIGNAL) &&
                    (CMD_BYTE <= CMD_STATUS);
  assign is_two_byte = (CMD_BYTE == CMD_SCOPE_KEY) ||
                       (CMD_BYTE == CMD_SCOPE_ROW) ||
                       (CMD_BYTE == CMD_SCOPE_COL);
  assign idle_take = (state_q == ST_IDLE) && CMD_VALID;
  assign arg_take  = (state_q == ST_ARG) && CMD_VALID;

  always_comb begin
    case (op_q)
      CMD_SCOPE_KEY: arg_ok = (CMD_BYTE <= KEY_MAX);
      CMD_SCOPE_ROW: arg_ok = (CMD_BYTE <= COORD_MAX);
      CMD_SCOPE_COL: arg_ok = (CMD_BYTE <= COORD_MAX);
      default:       arg_ok = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_q <= ST_IDLE;
      op_q    <= BYTE_ZERO;
    end else if (idle_take && is_two_byte) begin
      state_q <= ST_ARG;
      op_q    <= CMD_BYTE;
    end else if (arg_take) begin
      state_q <= ST_IDLE;
    end
  end

  // Scope survives every command except a valid scope command
  always_ff @(posedge CLK) begin
    if (SRST) begin
      scope_type_q <= SCOPE_ALL;
      scope_idx_q  <= KEY_ZERO;
    end else if (idle_take && CMD_BYTE == CMD_SCOPE_ALL) begin
      scope_type_q <= SCOPE_ALL;
      scope_idx_q  <= KEY_ZERO;
    end else if (arg_take && arg_ok) begin
      scope_idx_q <= CMD_BYTE[KEY_W-1:0];
      case (op_q)
        CMD_SCOPE_KEY: scope_type_q <= SCOPE_KEY;
        CMD_SCOPE_ROW: scope_type_q <= SCOPE_ROW;
        CMD_SCOPE_COL: scope_type_q <= SCOPE_COL;
        default:       scope_type_q <= scope_type_q;
      endcase
    end
  end

  // Anything not decoded leaves the response line quiet
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= (arg_take && arg_ok) ||
                     (idle_take && (is_query ||
                      CMD_BYTE == CMD_SCOPE_ALL));
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rsp_byte_q <= BYTE_ZERO;
    end else if (arg_take && arg_ok) begin
      rsp_byte_q <= op_q;
    end else if (idle_take) begin
      case (CMD_BYTE)
        CMD_SCOPE_ALL:  rsp_byte_q <= CMD_SCOPE_ALL;
        CMD_SIGNAL:     rsp_byte_q <= KEY_DATA.signal;
        CMD_DELTA:      rsp_byte_q <= delta;
        CMD_REFERENCE:  rsp_byte_q <= KEY_DATA.reference;
        CMD_LADDER:     rsp_byte_q <= KEY_DATA.ladder_dac_offset;
        CMD_CANCEL_CAP: rsp_byte_q <= {6'h00,
                                       KEY_DATA.cancel_cap_state};
        CMD_INTEGRATOR: rsp_byte_q <= KEY_DATA.integrator;
        CMD_CHECKSUM:   rsp_byte_q <= chk_sum;
        // Mismatch flag is its own input, not the sum
        CMD_STATUS:     rsp_byte_q <= {STAT_PAD, STATUS_IN};
        default:        rsp_byte_q <= rsp_byte_q;
      endcase
    end
  end

  assign RSP_VALID = rsp_valid_q;
  assign RSP_BYTE  = rsp_byte_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence arg_good_s;
    arg_take && arg_ok;
  endsequence
  sequence arg_bad_s;
    arg_take && !arg_ok;
  endsequence
  sequence query_s(logic [7:0] code);
    idle_take && CMD_BYTE == code;
  endsequence
  sequence scope_arg_s(logic [7:0] code);
    arg_take && arg_ok && op_q == code;
  endsequence

  reset_scope_all_a: assert property (
    @(posedge CLK) disable iff (1'b0) $past(SRST) |->
      scope_type_q == SCOPE_ALL && KEY_INDEX == KEY_ZERO)
    else $error("Scope not all keys after reset");
  scope_echo_a: assert property (
    arg_good_s |=> RSP_VALID && RSP_BYTE == $past(op_q))
    else $error("Scope command not echoed");
  key_scope_set_a: assert property (
    arg_good_s ##0 (op_q == CMD_SCOPE_KEY) |=>
      KEY_INDEX == $past(CMD_BYTE[KEY_W-1:0]))
    else $error("Single key scope not applied");
  col_lowest_key_a: assert property (
    scope_type_q == SCOPE_COL |->
      KEY_INDEX == {scope_idx_q[COORD_W-1:0], COORD_ZERO})
    else $error("Column scope addresses wrong key");
  row_lowest_key_a: assert property (
    scope_type_q == SCOPE_ROW |-> KEY_INDEX[KEY_W-1:COORD_W] == COORD_ZERO)
    else $error("Row scope addresses wrong key");
  bad_arg_drop_a: assert property (
    arg_bad_s |=> !RSP_VALID && $stable(scope_type_q) &&
      $stable(scope_idx_q))
    else $error("Out of range argument acted on");
  unknown_quiet_a: assert property (
    idle_take && !is_query && !is_two_byte &&
      CMD_BYTE != CMD_SCOPE_ALL |=> !RSP_VALID && state_q == ST_IDLE)
    else $error("Unknown command answered");
  delta_value_a: assert property (
    query_s(CMD_DELTA) |=> RSP_VALID && RSP_BYTE ==
      (($past(KEY_DATA.signal) > $past(KEY_DATA.reference)) ? BYTE_ZERO :
       $past(KEY_DATA.reference) - $past(KEY_DATA.signal)))
    else $error("Delta answer wrong");
  status_byte_a: assert property (
    query_s(CMD_STATUS) |=> RSP_VALID &&
      RSP_BYTE == {STAT_PAD, $past(STATUS_IN)})
    else $error("Status byte wrong");
  checksum_rsp_a: assert property (
    query_s(CMD_CHECKSUM) |=> RSP_VALID && RSP_BYTE == $past(chk_sum))
    else $error("Checksum answer wrong");
  scope_hold_a: assert property (
    !(arg_take && arg_ok) &&
      !(idle_take && CMD_BYTE == CMD_SCOPE_ALL) |=>
      $stable(scope_type_q) && $stable(scope_idx_q))
    else $error("Scope changed without scope command");

  // Scope arguments land as the lowest key of the new scope
  row_arg_key_a: assert property (
    scope_arg_s(CMD_SCOPE_ROW) |=>
      KEY_INDEX == KEY_W'($past(CMD_BYTE[COORD_W-1:0])))
    else $error("Row argument not applied");
  col_arg_key_a: assert property (
    scope_arg_s(CMD_SCOPE_COL) |=>
      KEY_INDEX == {$past(CMD_BYTE[COORD_W-1:0]), COORD_ZERO})
    else $error("Column argument not applied");
  all_scope_key_a: assert property (
    query_s(CMD_SCOPE_ALL) |=> RSP_VALID &&
      RSP_BYTE == CMD_SCOPE_ALL && KEY_INDEX == KEY_ZERO)
    else $error("All keys scope not applied");
  first_byte_quiet_a: assert property (
    idle_take && is_two_byte |=> !RSP_VALID && state_q == ST_ARG)
    else $error("Scope command answered before its argument");
  arg_return_idle_a: assert property (
    arg_take |=> state_q == ST_IDLE)
    else $error("Argument byte left interpreter waiting");

  // Answers only follow a taken byte; the byte stands in between
  no_byte_quiet_a: assert property (
    !CMD_VALID |=> !RSP_VALID)
    else $error("Answer without a command byte");
  rsp_byte_hold_a: assert property (
    !RSP_VALID && !$past(SRST) |-> $stable(RSP_BYTE))
    else $error("Response byte changed without an answer");

  // Every per-key query answers with the reading taken with the command
  signal_rsp_a: assert property (
    query_s(CMD_SIGNAL) |=> RSP_VALID &&
      RSP_BYTE == $past(KEY_DATA.signal))
    else $error("Signal answer wrong");
  reference_rsp_a: assert property (
    query_s(CMD_REFERENCE) |=> RSP_VALID &&
      RSP_BYTE == $past(KEY_DATA.reference))
    else $error("Reference answer wrong");
  ladder_rsp_a: assert property (
    query_s(CMD_LADDER) |=> RSP_VALID &&
      RSP_BYTE == $past(KEY_DATA.ladder_dac_offset))
    else $error("Ladder offset answer wrong");
  cancel_cap_rsp_a: assert property (
    query_s(CMD_CANCEL_CAP) |=> RSP_VALID &&
      RSP_BYTE == BYTE_W'($past(KEY_DATA.cancel_cap_state)))
    else $error("Cancel capacitor answer wrong");
  integrator_rsp_a: assert property (
    query_s(CMD_INTEGRATOR) |=> RSP_VALID &&
      RSP_BYTE == $past(KEY_DATA.integrator))
    else $error("Integrator answer wrong");
  delta_clamp_a: assert property (
    query_s(CMD_DELTA) ##0 (KEY_DATA.signal > KEY_DATA.reference) |=>
      RSP_VALID && RSP_BYTE == BYTE_ZERO)
    else $error("Delta not clamped to zero");

endmodule

// ---- kss_pkg.sv ----
// Constants, command codes and carrier types for the key scope and
// status command interpreter.
// Assumes one clock domain and a byte-wide command stream.
package kss_pkg;

  localparam int KEY_W   = 6;
  localparam int COORD_W = 3;
  localparam int BYTE_W  = 8;

  // Command codes
  localparam logic [7:0] CMD_SCOPE_KEY  = 8'h73;
  localparam logic [7:0] CMD_SCOPE_ALL  = 8'h53;
  localparam logic [7:0] CMD_SCOPE_ROW  = 8'h78;
  localparam logic [7:0] CMD_SCOPE_COL  = 8'h79;
  localparam logic [7:0] CMD_SIGNAL     = 8'h30;
  localparam logic [7:0] CMD_DELTA      = 8'h31;
  localparam logic [7:0] CMD_REFERENCE  = 8'h32;
  localparam logic [7:0] CMD_LADDER     = 8'h33;
  localparam logic [7:0] CMD_CANCEL_CAP = 8'h34;
  localparam logic [7:0] CMD_INTEGRATOR = 8'h35;
  localparam logic [7:0] CMD_CHECKSUM   = 8'h36;
  localparam logic [7:0] CMD_STATUS     = 8'h37;

  // Upper limits of the second byte
  localparam logic [7:0] KEY_MAX   = 8'h3f;
  localparam logic [7:0] COORD_MAX = 8'h07;

  localparam logic [7:0]         BYTE_ZERO  = 8'h00;
  localparam logic [KEY_W-1:0]   KEY_ZERO   = 6'h00;
  localparam logic [COORD_W-1:0] COORD_ZERO = 3'h0;
  localparam logic [2:0]         STAT_PAD   = 3'h0;

  typedef enum logic [1:0] {
    SCOPE_ALL,
    SCOPE_KEY,
    SCOPE_ROW,
    SCOPE_COL
  } kss_scope_type;

  // Per-key readings for the key the interpreter currently addresses
  typedef struct packed {
    logic [7:0] signal;
    logic [7:0] reference;
    logic [7:0] ladder_dac_offset;
    logic [1:0] cancel_cap_state;
    logic [7:0] integrator;
  } kss_key_data_type;

  // General status inputs, msb is the memory mismatch flag (bit 4)
  typedef struct packed {
    logic mem_mismatch;
    logic sync_fail;
    logic any_error;
    logic any_recal;
    logic any_detect;
  } kss_status_type;

endpackage

// ---- tb_key_scope_status_commands.sv ----
// Self-checking bench for the key scope and status interpreter.
// Assumes the far-side model supplies key readings and setup memory.
`timescale 1ns/100ps
module tb_key_scope_status_commands;
  import kss_pkg::*;
  import kss_tb_pkg::*;

  logic             clk, srst, cmd_valid, flip, rsp_valid;
  logic [7:0]       cmd_byte, rsp_byte, mem_data;
  logic [5:0]       key_index;
  logic [3:0]       mem_addr;
  kss_key_data_type key_data;
  kss_status_type   status_in;
  int               n_mismatch, comparisons, cycles;

  // Short memory keeps each checksum pass to a few cycles
  kss_interp #(.MEM_DEPTH(16), .MEM_ADDR_W(4)) kss_interp_i (
    .CLK(clk), .SRST(srst), .CMD_VALID(cmd_valid), .CMD_BYTE(cmd_byte),
    .RSP_VALID(rsp_valid), .RSP_BYTE(rsp_byte), .KEY_INDEX(key_index),
    .KEY_DATA(key_data), .STATUS_IN(status_in), .MEM_ADDR(mem_addr),
    .MEM_DATA(mem_data));

  kss_far_model kss_far_model_i (
    .clk(clk), .key_index(key_index), .mem_addr(mem_addr), .flip(flip),
    .key_data(key_data), .mem_data(mem_data));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One strobed byte; returns {RSP_VALID, RSP_BYTE} one cycle later
  task automatic xfer(input logic [7:0] b, output logic [8:0] r);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_byte  <= b;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    r = {rsp_valid, rsp_byte};
  endtask

  task automatic q(input logic [7:0] c, input logic [7:0] exp);
    logic [8:0] r;
    xfer(c, r);
    chk(r, {1'b1, exp});
  endtask

  task automatic silent(input logic [7:0] c);
    logic [8:0] r;
    xfer(c, r);
    chk({8'h00, r[8]}, 9'h000);
  endtask

  task automatic sc(input logic [7:0] c, input logic [7:0] a,
                    input logic [5:0] k, input logic ok);
    logic [8:0] r;
    silent(c);
    xfer(a, r);
    chk(ok ? r : {8'h00, r[8]}, ok ? {1'b1, c} : 9'h000);
    chk({3'h0, key_index}, {3'h0, k});
  endtask

  task automatic keyq(input logic [5:0] k);
    kss_key_data_type d;
    d = key_val(k);
    q(CMD_SIGNAL, d.signal);
    q(CMD_DELTA, d.reference >= d.signal ?
      d.reference - d.signal : 8'h00);
    q(CMD_REFERENCE, d.reference);
    q(CMD_LADDER, d.ladder_dac_offset);
    q(CMD_CANCEL_CAP, {6'h00, d.cancel_cap_state});
    q(CMD_INTEGRATOR, d.integrator);
  endtask

  function automatic logic [7:0] fold(input logic f);
    logic [8:0] s;
    fold = 8'h00;
    for (int a = 0; a < 16; a++) begin
      s    = {1'b0, fold} + {1'b0, mem_val(4'(a), f)};
      fold = s[7:0] + {7'h00, s[8]};
    end
  endfunction

  task automatic t_reset;
    chk({3'h0, key_index}, 9'h000);
    keyq(6'h00);
    $display("test reset done");
  endtask

  task automatic t_scopes;
    logic [8:0] r;
    sc(CMD_SCOPE_KEY, 8'h3f, 6'h3f, 1'b1);
    keyq(6'h3f);
    sc(CMD_SCOPE_KEY, 8'h0b, 6'h0b, 1'b1);
    sc(CMD_SCOPE_ROW, 8'h07, 6'h07, 1'b1);
    keyq(6'h07);
    sc(CMD_SCOPE_COL, 8'h05, 6'h28, 1'b1);
    keyq(6'h28);
    xfer(CMD_SCOPE_ALL, r);
    chk(r, {1'b1, CMD_SCOPE_ALL});
    keyq(6'h00);
    $display("test scopes done");
  endtask

  task automatic t_refuse;
    sc(CMD_SCOPE_ROW, 8'h03, 6'h03, 1'b1);
    sc(CMD_SCOPE_KEY, 8'h40, 6'h03, 1'b0);
    sc(CMD_SCOPE_ROW, 8'h08, 6'h03, 1'b0);
    sc(CMD_SCOPE_COL, 8'hff, 6'h03, 1'b0);
    silent(8'h00);
    silent(8'h70);
    silent(8'h38);
    keyq(6'h03);
    // A command-like argument must be taken as a key number
    sc(CMD_SCOPE_KEY, CMD_SIGNAL, 6'h30, 1'b1);
    $display("test refuse done");
  endtask

  task automatic t_status;
    logic [4:0] v;
    for (int i = 0; i < 7; i++) begin
      v = (i < 5) ? 5'(1 << i) : (i == 5 ? 5'h1f : 5'h00);
      @(posedge clk);
      status_in <= kss_status_type'(v);
      q(CMD_STATUS, {3'h0, v});
    end
    $display("test status done");
  endtask

  task automatic t_checksum;
    q(CMD_CHECKSUM, fold(1'b0));
    @(posedge clk);
    flip <= 1'b1;
    // Three full passes so the latched sum covers the altered byte
    repeat (52) @(posedge clk);
    q(CMD_CHECKSUM, fold(1'b1));
    q(CMD_STATUS, 8'h00);
    sc(CMD_SCOPE_ROW, 8'h02, 6'h02, 1'b1);
    q(CMD_CHECKSUM, fold(1'b1));
    @(posedge clk);
    status_in <= kss_status_type'(5'h15);
    q(CMD_STATUS, 8'h15);
    $display("test checksum done");
  endtask

  // Reset in mid-run must drop a narrow scope back to all keys
  task automatic t_rereset;
    sc(CMD_SCOPE_COL, 8'h07, 6'h38, 1'b1);
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    chk({3'h0, key_index}, 9'h000);
    keyq(6'h00);
    $display("test rereset done");
  endtask

  initial begin
    srst        = 1'b1;
    cmd_valid   = 1'b0;
    cmd_byte    = 8'h00;
    flip        = 1'b0;
    status_in   = '0;
    n_mismatch  = 0;
    comparisons = 0;
    cycles      = 0;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_scopes();
    t_refuse();
    t_status();
    t_checksum();
    t_rereset();
    finish_test();
  end
endmodule
